// [verilog/pbf_pkg.sv]
`default_nettype none

package pbf_pkg;

  localparam int unsigned DATA_W = 16;
  localparam int unsigned ADDR_W = 4;
  localparam int unsigned PIN_N  = 16;

  // register offsets
  localparam logic [3:0] OFS_HIGH_SEL = 4'h0;
  localparam logic [3:0] OFS_LOW_SEL  = 4'h2;
  localparam logic [3:0] OFS_PIN_STAT = 4'h4;

  // power-on reset values
  localparam logic [15:0] RST_HIGH_SEL = 16'h0000;
  localparam logic [15:0] RST_LOW_SEL  = 16'h0000;

  // mode field layout: pin p uses bits 2p+1:2p of {high, low}
  localparam int unsigned MODE_W = 2;

  // mode codes
  localparam logic [1:0] MODE_GPIO = 2'h0;
  localparam logic [1:0] MODE_A    = 2'h1;
  localparam logic [1:0] MODE_B    = 2'h2;
  localparam logic [1:0] MODE_C    = 2'h3;

  // prescaler codes that pick an external timer clock
  localparam logic [2:0] PSC_EXT_A = 3'h4;
  localparam logic [2:0] PSC_EXT_C = 3'h6;
  localparam logic [2:0] PSC_EXT_D = 3'h7;

  // level fed to an async receiver that is not routed
  localparam logic RX_IDLE = 1'h1;

endpackage

`default_nettype wire

// [verilog/pbf_pin_function.sv]
`timescale 1ns/10ps
`default_nettype none

module pbf_pin_function
  import pbf_pkg::*;
(
  input  wire logic              clk_sys_i,
  input  wire logic              rst_i,
  // register port
  input  wire logic [ADDR_W-1:0] addr_i,
  input  wire logic [DATA_W-1:0] wr_data_i,
  input  wire logic              wr_stb_i,
  input  wire logic              rd_stb_i,
  output logic      [DATA_W-1:0] rd_data_o,
  // pads
  input  wire logic [PIN_N-1:0]  pad_in_i,
  output logic      [PIN_N-1:0]  pad_out_o,
  output logic      [PIN_N-1:0]  pad_oe_o,
  // general i/o port
  input  wire logic [PIN_N-1:0]  gpio_out_i,
  input  wire logic [PIN_N-1:0]  gpio_oe_i,
  output logic      [PIN_N-1:0]  gpio_in_o,
  // timer clock selection
  input  wire logic              timer_phase_count_i,
  input  wire logic [2:0]        timer_prescale_select_i,
  // peripheral outputs toward pads
  input  wire logic              async1_serial_clock_out_i,
  input  wire logic              async1_serial_clock_oe_i,
  input  wire logic              async1_transmit_data_i,
  input  wire logic              async1_transmit_request_i,
  input  wire logic              bus_status_bit1_i,
  input  wire logic              bus_status_bit0_i,
  input  wire logic              timer1_capcomp_a_out_i,
  input  wire logic              timer1_capcomp_a_oe_i,
  input  wire logic              timer1_capcomp_b_out_i,
  input  wire logic              timer1_capcomp_b_oe_i,
  input  wire logic              sync2_transmit_sync_out_i,
  input  wire logic              sync2_transmit_sync_oe_i,
  input  wire logic              timer2_capcomp_a_out_i,
  input  wire logic              timer2_capcomp_a_oe_i,
  input  wire logic              sync2_transmit_data_i,
  input  wire logic              timer2_capcomp_b_out_i,
  input  wire logic              timer2_capcomp_b_oe_i,
  input  wire logic              async2_serial_clock_out_i,
  input  wire logic              async2_serial_clock_oe_i,
  input  wire logic              async2_transmit_data_i,
  input  wire logic              timer0_capcomp_a_out_i,
  input  wire logic              timer0_capcomp_a_oe_i,
  input  wire logic              sync1_transmit_sync_out_i,
  input  wire logic              sync1_transmit_sync_oe_i,
  input  wire logic              timer0_capcomp_b_out_i,
  input  wire logic              timer0_capcomp_b_oe_i,
  input  wire logic              sync1_transmit_data_i,
  input  wire logic              timer0_capcomp_c_out_i,
  input  wire logic              timer0_capcomp_c_oe_i,
  input  wire logic              timer0_capcomp_d_out_i,
  input  wire logic              timer0_capcomp_d_oe_i,
  input  wire logic              wake_on_lan_output_i,
  // pad inputs toward peripherals
  output logic                   async1_serial_clock_in_o,
  output logic                   async1_receive_data_o,
  output logic                   sync2_receive_clock_o,
  output logic                   async1_clear_to_send_o,
  output logic                   sync2_receive_sync_o,
  output logic                   sync2_receive_data_o,
  output logic                   timer1_capcomp_a_in_o,
  output logic                   sync2_transmit_clock_o,
  output logic                   timer1_capcomp_b_in_o,
  output logic                   timer_ext_clock_c_o,
  output logic                   sync2_transmit_sync_in_o,
  output logic                   timer2_capcomp_a_in_o,
  output logic                   timer2_capcomp_b_in_o,
  output logic                   timer_ext_clock_d_o,
  output logic                   sync1_receive_clock_o,
  output logic                   async2_serial_clock_in_o,
  output logic                   sync1_receive_sync_o,
  output logic                   async2_receive_data_o,
  output logic                   sync1_receive_data_o,
  output logic                   sync1_transmit_clock_o,
  output logic                   timer0_capcomp_a_in_o,
  output logic                   sync1_transmit_sync_in_o,
  output logic                   timer0_capcomp_b_in_o,
  output logic                   timer0_capcomp_c_in_o,
  output logic                   timer_ext_clock_a_o,
  output logic                   timer0_capcomp_d_in_o
);

  logic [DATA_W-1:0]   high_sel_q;
  logic [DATA_W-1:0]   low_sel_q;
  logic [PIN_N-1:0]    pin_m_q;
  logic [PIN_N-1:0]    pin_s_q;
  logic [2*PIN_N-1:0]  all_sel;
  logic [MODE_W-1:0]   mode [PIN_N];
  logic                fo [PIN_N][4];
  logic                fe [PIN_N][4];
  logic [PIN_N-1:0]    pad_out_d;
  logic [PIN_N-1:0]    pad_oe_d;
  logic                ext_a_use;
  logic                ext_c_use;
  logic                ext_d_use;

  // pin p mode field sits at bits 2p+1:2p of {high, low}
  assign all_sel = {high_sel_q, low_sel_q};

  always_comb begin
    for (int p = 0; p < PIN_N; p++) begin
      mode[p] = all_sel[MODE_W*p +: MODE_W];
    end
  end

  // pad input value for a peripheral, or an idle level when not routed
  function automatic logic pick(input logic [1:0] m,
                                input logic [1:0] want,
                                input logic       v,
                                input logic       idle);
    pick = (m == want) ? v : idle;
  endfunction

  // two-stage pad synchroniser
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      pin_m_q <= '0;
      pin_s_q <= '0;
    end else begin
      pin_m_q <= pad_in_i;
      pin_s_q <= pin_m_q;
    end
  end

  // control registers, cleared by power-on reset only
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      high_sel_q <= RST_HIGH_SEL;
      low_sel_q  <= RST_LOW_SEL;
    end else if (wr_stb_i) begin
      if (addr_i == OFS_HIGH_SEL) begin
        high_sel_q <= wr_data_i;
      end
      if (addr_i == OFS_LOW_SEL) begin
        low_sel_q <= wr_data_i;
      end
    end
  end

  // read data stands only in the cycle after the strobe
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      rd_data_o <= '0;
    end else if (rd_stb_i) begin
      unique case (addr_i)
        OFS_HIGH_SEL: rd_data_o <= high_sel_q;
        OFS_LOW_SEL:  rd_data_o <= low_sel_q;
        OFS_PIN_STAT: rd_data_o <= pin_s_q;
        default:      rd_data_o <= '0;
      endcase
    end else begin
      rd_data_o <= '0;
    end
  end

  // external timer clock takes the pin over as an input
  always_comb begin
    ext_c_use = (mode[9] == MODE_B) &&
                (timer_phase_count_i || timer_prescale_select_i == PSC_EXT_C);
    ext_d_use = (mode[7] == MODE_B) &&
                (timer_phase_count_i || timer_prescale_select_i == PSC_EXT_D);
    ext_a_use = (mode[1] == MODE_B) &&
                (timer_phase_count_i || timer_prescale_select_i == PSC_EXT_A);
  end

  // per pin, per mode output value and enable
  always_comb begin
    for (int p = 0; p < PIN_N; p++) begin
      for (int m = 0; m < 4; m++) begin
        // gpio, and reserved codes fall back to gpio
        fo[p][m] = gpio_out_i[p];
        fe[p][m] = gpio_oe_i[p];
      end
    end
    // input-only functions release the pad
    fo[15][MODE_B] = async1_serial_clock_out_i;
    fe[15][MODE_B] = async1_serial_clock_oe_i;
    fo[14][MODE_B] = 1'h0;
    fe[14][MODE_B] = 1'h0;
    fo[13][MODE_B] = async1_transmit_data_i;
    fe[13][MODE_B] = 1'h1;
    fo[12][MODE_A] = 1'h0;
    fe[12][MODE_A] = 1'h0;
    fo[12][MODE_B] = async1_transmit_request_i;
    fe[12][MODE_B] = 1'h1;
    fo[12][MODE_C] = bus_status_bit1_i;
    fe[12][MODE_C] = 1'h1;
    fo[11][MODE_A] = 1'h0;
    fe[11][MODE_A] = 1'h0;
    fo[11][MODE_B] = 1'h0;
    fe[11][MODE_B] = 1'h0;
    fo[11][MODE_C] = bus_status_bit0_i;
    fe[11][MODE_C] = 1'h1;
    fo[10][MODE_A] = 1'h0;
    fe[10][MODE_A] = 1'h0;
    fo[10][MODE_B] = timer1_capcomp_a_out_i;
    fe[10][MODE_B] = timer1_capcomp_a_oe_i;
    fo[9][MODE_A]  = 1'h0;
    fe[9][MODE_A]  = 1'h0;
    fo[9][MODE_B]  = timer1_capcomp_b_out_i;
    fe[9][MODE_B]  = timer1_capcomp_b_oe_i && !ext_c_use;
    fo[8][MODE_A]  = sync2_transmit_sync_out_i;
    fe[8][MODE_A]  = sync2_transmit_sync_oe_i;
    fo[8][MODE_B]  = timer2_capcomp_a_out_i;
    fe[8][MODE_B]  = timer2_capcomp_a_oe_i;
    fo[7][MODE_A]  = sync2_transmit_data_i;
    fe[7][MODE_A]  = 1'h1;
    fo[7][MODE_B]  = timer2_capcomp_b_out_i;
    fe[7][MODE_B]  = timer2_capcomp_b_oe_i && !ext_d_use;
    fo[6][MODE_A]  = 1'h0;
    fe[6][MODE_A]  = 1'h0;
    fo[6][MODE_B]  = async2_serial_clock_out_i;
    fe[6][MODE_B]  = async2_serial_clock_oe_i;
    fo[5][MODE_A]  = 1'h0;
    fe[5][MODE_A]  = 1'h0;
    fo[5][MODE_B]  = 1'h0;
    fe[5][MODE_B]  = 1'h0;
    fo[4][MODE_A]  = 1'h0;
    fe[4][MODE_A]  = 1'h0;
    fo[4][MODE_B]  = async2_transmit_data_i;
    fe[4][MODE_B]  = 1'h1;
    fo[3][MODE_A]  = 1'h0;
    fe[3][MODE_A]  = 1'h0;
    fo[3][MODE_B]  = timer0_capcomp_a_out_i;
    fe[3][MODE_B]  = timer0_capcomp_a_oe_i;
    fo[2][MODE_A]  = sync1_transmit_sync_out_i;
    fe[2][MODE_A]  = sync1_transmit_sync_oe_i;
    fo[2][MODE_B]  = timer0_capcomp_b_out_i;
    fe[2][MODE_B]  = timer0_capcomp_b_oe_i;
    fo[1][MODE_A]  = sync1_transmit_data_i;
    fe[1][MODE_A]  = 1'h1;
    fo[1][MODE_B]  = timer0_capcomp_c_out_i;
    fe[1][MODE_B]  = timer0_capcomp_c_oe_i && !ext_a_use;
    // pin 0 code 01 is reserved and stays on the general path
    fo[0][MODE_A]  = gpio_out_i[0];
    fe[0][MODE_A]  = gpio_oe_i[0];
    fo[0][MODE_B]  = timer0_capcomp_d_out_i;
    fe[0][MODE_B]  = timer0_capcomp_d_oe_i;
    fo[0][MODE_C]  = wake_on_lan_output_i;
    fe[0][MODE_C]  = 1'h1;
  end

  always_comb begin
    for (int p = 0; p < PIN_N; p++) begin
      pad_out_d[p] = fo[p][mode[p]];
      pad_oe_d[p]  = fe[p][mode[p]];
    end
  end

  // pad drive
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      pad_out_o <= '0;
      pad_oe_o  <= '0;
    end else begin
      pad_out_o <= pad_out_d;
      pad_oe_o  <= pad_oe_d;
    end
  end

  // general input always reflects the pin state
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      gpio_in_o <= '0;
    end else begin
      gpio_in_o <= pin_s_q;
    end
  end

  // pad inputs routed to the selected peripheral
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      async1_serial_clock_in_o <= 1'h0;
      async1_receive_data_o    <= RX_IDLE;
      sync2_receive_clock_o    <= 1'h0;
      async1_clear_to_send_o   <= 1'h0;
      sync2_receive_sync_o     <= 1'h0;
      sync2_receive_data_o     <= 1'h0;
      timer1_capcomp_a_in_o    <= 1'h0;
      sync2_transmit_clock_o   <= 1'h0;
      timer1_capcomp_b_in_o    <= 1'h0;
      sync2_transmit_sync_in_o <= 1'h0;
      timer2_capcomp_a_in_o    <= 1'h0;
      timer2_capcomp_b_in_o    <= 1'h0;
      sync1_receive_clock_o    <= 1'h0;
      async2_serial_clock_in_o <= 1'h0;
      sync1_receive_sync_o     <= 1'h0;
      async2_receive_data_o    <= RX_IDLE;
      sync1_receive_data_o     <= 1'h0;
      sync1_transmit_clock_o   <= 1'h0;
      timer0_capcomp_a_in_o    <= 1'h0;
      sync1_transmit_sync_in_o <= 1'h0;
      timer0_capcomp_b_in_o    <= 1'h0;
      timer0_capcomp_c_in_o    <= 1'h0;
      timer0_capcomp_d_in_o    <= 1'h0;
    end else begin
      async1_serial_clock_in_o <= pick(mode[15], MODE_B, pin_s_q[15], 1'h0);
      async1_receive_data_o    <= pick(mode[14], MODE_B, pin_s_q[14], RX_IDLE);
      sync2_receive_clock_o    <= pick(mode[12], MODE_A, pin_s_q[12], 1'h0);
      async1_clear_to_send_o   <= pick(mode[11], MODE_B, pin_s_q[11], 1'h0);
      sync2_receive_sync_o     <= pick(mode[11], MODE_A, pin_s_q[11], 1'h0);
      sync2_receive_data_o     <= pick(mode[10], MODE_A, pin_s_q[10], 1'h0);
      timer1_capcomp_a_in_o    <= pick(mode[10], MODE_B, pin_s_q[10], 1'h0);
      sync2_transmit_clock_o   <= pick(mode[9], MODE_A, pin_s_q[9], 1'h0);
      timer1_capcomp_b_in_o    <= pick(mode[9], MODE_B, pin_s_q[9], 1'h0);
      sync2_transmit_sync_in_o <= pick(mode[8], MODE_A, pin_s_q[8], 1'h0);
      timer2_capcomp_a_in_o    <= pick(mode[8], MODE_B, pin_s_q[8], 1'h0);
      timer2_capcomp_b_in_o    <= pick(mode[7], MODE_B, pin_s_q[7], 1'h0);
      sync1_receive_clock_o    <= pick(mode[6], MODE_A, pin_s_q[6], 1'h0);
      async2_serial_clock_in_o <= pick(mode[6], MODE_B, pin_s_q[6], 1'h0);
      sync1_receive_sync_o     <= pick(mode[5], MODE_A, pin_s_q[5], 1'h0);
      async2_receive_data_o    <= pick(mode[5], MODE_B, pin_s_q[5], RX_IDLE);
      sync1_receive_data_o     <= pick(mode[4], MODE_A, pin_s_q[4], 1'h0);
      sync1_transmit_clock_o   <= pick(mode[3], MODE_A, pin_s_q[3], 1'h0);
      timer0_capcomp_a_in_o    <= pick(mode[3], MODE_B, pin_s_q[3], 1'h0);
      sync1_transmit_sync_in_o <= pick(mode[2], MODE_A, pin_s_q[2], 1'h0);
      timer0_capcomp_b_in_o    <= pick(mode[2], MODE_B, pin_s_q[2], 1'h0);
      timer0_capcomp_c_in_o    <= pick(mode[1], MODE_B, pin_s_q[1], 1'h0);
      timer0_capcomp_d_in_o    <= pick(mode[0], MODE_B, pin_s_q[0], 1'h0);
    end
  end

  // external timer clocks
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      timer_ext_clock_a_o <= 1'h0;
      timer_ext_clock_c_o <= 1'h0;
      timer_ext_clock_d_o <= 1'h0;
    end else begin
      timer_ext_clock_a_o <= ext_a_use && pin_s_q[1];
      timer_ext_clock_c_o <= ext_c_use && pin_s_q[9];
      timer_ext_clock_d_o <= ext_d_use && pin_s_q[7];
    end
  end

endmodule

`default_nettype wire

// [tb/pbf_pin_function_properties.sv]
`timescale 1ns/10ps
`default_nettype none

module pbf_pin_function_properties
  import pbf_pkg::*;
(
  input wire logic              clk_sys_i,
  input wire logic              rst_i,
  input wire logic [ADDR_W-1:0] addr_i,
  input wire logic [DATA_W-1:0] wr_data_i,
  input wire logic              wr_stb_i,
  input wire logic              rd_stb_i,
  input wire logic [DATA_W-1:0] rd_data_o,
  input wire logic [PIN_N-1:0]  pad_in_i,
  input wire logic [PIN_N-1:0]  pad_out_o,
  input wire logic [PIN_N-1:0]  pad_oe_o,
  input wire logic [PIN_N-1:0]  gpio_out_i,
  input wire logic [PIN_N-1:0]  gpio_oe_i,
  input wire logic              timer_phase_count_i,
  input wire logic [2:0]        timer_prescale_select_i,
  input wire logic              async1_transmit_data_i,
  input wire logic              bus_status_bit1_i,
  input wire logic              wake_on_lan_output_i,
  input wire logic              async1_receive_data_o,
  input wire logic              timer_ext_clock_a_o
);
  logic [15:0] hi_q;
  logic [15:0] lo_q;
  logic        ext_a;
  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (rst_i);
  // shadow copies of the two select registers
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      hi_q <= RST_HIGH_SEL;
    end else if (wr_stb_i && addr_i == OFS_HIGH_SEL) begin
      hi_q <= wr_data_i;
    end
  end
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      lo_q <= RST_LOW_SEL;
    end else if (wr_stb_i && addr_i == OFS_LOW_SEL) begin
      lo_q <= wr_data_i;
    end
  end
  assign ext_a = lo_q[3:2] == MODE_B && (timer_phase_count_i || timer_prescale_select_i == PSC_EXT_A);
  rd_idle_a: assert property (!rd_stb_i |=> rd_data_o == 16'h0000)
    else $error("read data not zero outside a read");
  rd_low_a: assert property (rd_stb_i && addr_i == OFS_LOW_SEL |=> rd_data_o == lo_q)
    else $error("low select read mismatch");
  rd_high_a: assert property (rd_stb_i && addr_i == OFS_HIGH_SEL |=> rd_data_o == hi_q)
    else $error("high select read mismatch");
  tx1_route_a: assert property (hi_q[11:10] == MODE_B
    |=> pad_oe_o[13] && pad_out_o[13] == $past(async1_transmit_data_i))
    else $error("pin 13 transmit route wrong");
  rx1_route_a: assert property (hi_q[13:12] == MODE_B [*3]
    |=> async1_receive_data_o == $past(pad_in_i[14], 3))
    else $error("pin 14 receive route wrong");
  rx1_idle_a: assert property (hi_q[13:12] != MODE_B |=> async1_receive_data_o == RX_IDLE)
    else $error("unrouted receive not idle");
  wol_route_a: assert property (lo_q[1:0] == MODE_C
    |=> pad_oe_o[0] && pad_out_o[0] == $past(wake_on_lan_output_i))
    else $error("pin 0 wake output wrong");
  stat1_route_a: assert property (hi_q[9:8] == MODE_C
    |=> pad_oe_o[12] && pad_out_o[12] == $past(bus_status_bit1_i))
    else $error("pin 12 status output wrong");
  resv_gpio_a: assert property (hi_q[15:14] != MODE_B
    |=> pad_out_o[15] == $past(gpio_out_i[15]) && pad_oe_o[15] == $past(gpio_oe_i[15]))
    else $error("pin 15 general path wrong");
  ext_clk_a_a: assert property (ext_a [*3]
    |=> timer_ext_clock_a_o == $past(pad_in_i[1], 3) && !pad_oe_o[1])
    else $error("external clock a route wrong");
  ext_idle_a: assert property (!ext_a |=> !timer_ext_clock_a_o)
    else $error("external clock a not idle");
endmodule

`default_nettype wire

// [tb/pbf_far_side.sv]
`timescale 1ns/10ps
`default_nettype none

module pbf_far_side (
  input  wire logic        clk_sys_i,
  input  wire logic [15:0] pad_out_i,
  input  wire logic [15:0] pad_oe_i,
  input  wire logic [15:0] ext_val_i,
  input  wire logic [15:0] ext_oe_i,
  output logic      [15:0] pad_lvl_o,
  output logic      [31:0] per_o,
  output logic      [31:0] per_prev_o
);
  logic [15:0] last_q = 16'h0000;
  logic [31:0] per_q  = 32'h5a3c96e1;
  logic [31:0] prev_q = 32'h00000000;
  // pad level: block first, outside driver next, else a float that flips each cycle
  assign pad_lvl_o = (pad_oe_i & pad_out_i) | (~pad_oe_i & ext_oe_i & ext_val_i)
                   | (~pad_oe_i & ~ext_oe_i & ~last_q);
  assign per_o = per_q;
  assign per_prev_o = prev_q;
  // peripheral outputs wander every cycle
  always @(posedge clk_sys_i) begin
    per_q <= {per_q[30:0], per_q[31] ^ per_q[21] ^ per_q[1] ^ per_q[0]};
    prev_q <= per_q;
    last_q <= pad_lvl_o;
  end
endmodule

`default_nettype wire

// [tb/pbf_pin_function_tb.sv]
`timescale 1ns/10ps
`default_nettype none
`define CHK(a, b) begin comparisons++; if ((a) !== (b)) begin n_fail++; \
  $display("BAD %0t %h %h", $time, (a), (b)); end end

module pbf_pin_function_tb;
  import pbf_pkg::*;
  logic        clk_sys_i = 1'b0;
  logic        rst_i     = 1'b1;
  logic [3:0]  addr_i    = 4'h0;
  logic [15:0] wr_data_i = 16'h0000;
  logic        wr_stb_i  = 1'b0;
  logic        rd_stb_i  = 1'b0;
  logic [15:0] gpio_out_i = 16'h0000, gpio_oe_i = 16'h0000;
  logic [15:0] ext_val    = 16'h0000, ext_oe = 16'hffff;
  logic        timer_phase_count_i = 1'b0;
  logic [2:0]  timer_prescale_select_i = 3'h0;
  int          n_fail = 0, comparisons = 0;
  wire logic [31:0] pv, pq;
  wire logic [15:0] rd_data_o, pad_out_o, pad_oe_o, gpio_in_o, pad_in_i;
  wire logic async1_serial_clock_out_i = pv[0], async1_serial_clock_oe_i = pv[1],
    async1_transmit_data_i = pv[2], async1_transmit_request_i = pv[3], bus_status_bit1_i = pv[4],
    bus_status_bit0_i = pv[5], timer1_capcomp_a_out_i = pv[6], timer1_capcomp_a_oe_i = pv[7],
    timer1_capcomp_b_out_i = pv[8], timer1_capcomp_b_oe_i = pv[9],
    sync2_transmit_sync_out_i = pv[10], sync2_transmit_sync_oe_i = pv[11],
    timer2_capcomp_a_out_i = pv[12], timer2_capcomp_a_oe_i = pv[13], sync2_transmit_data_i = pv[14],
    timer2_capcomp_b_out_i = pv[15], timer2_capcomp_b_oe_i = pv[16],
    async2_serial_clock_out_i = pv[17], async2_serial_clock_oe_i = pv[18],
    async2_transmit_data_i = pv[19], timer0_capcomp_a_out_i = pv[20], timer0_capcomp_a_oe_i = pv[21],
    sync1_transmit_sync_out_i = pv[22], sync1_transmit_sync_oe_i = pv[23],
    timer0_capcomp_b_out_i = pv[24], timer0_capcomp_b_oe_i = pv[25], sync1_transmit_data_i = pv[26],
    timer0_capcomp_c_out_i = pv[27], timer0_capcomp_c_oe_i = pv[28],
    timer0_capcomp_d_out_i = pv[29], timer0_capcomp_d_oe_i = pv[30], wake_on_lan_output_i = pv[31];
  wire logic async1_serial_clock_in_o, async1_receive_data_o, sync2_receive_clock_o,
    async1_clear_to_send_o, sync2_receive_sync_o, sync2_receive_data_o, timer1_capcomp_a_in_o,
    sync2_transmit_clock_o, timer1_capcomp_b_in_o, timer_ext_clock_c_o, sync2_transmit_sync_in_o,
    timer2_capcomp_a_in_o, timer2_capcomp_b_in_o, timer_ext_clock_d_o, sync1_receive_clock_o,
    async2_serial_clock_in_o, sync1_receive_sync_o, async2_receive_data_o, sync1_receive_data_o,
    sync1_transmit_clock_o, timer0_capcomp_a_in_o, sync1_transmit_sync_in_o,
    timer0_capcomp_b_in_o, timer0_capcomp_c_in_o, timer_ext_clock_a_o, timer0_capcomp_d_in_o;

  pbf_pin_function i_pbf_pin_function (.*);
  pbf_far_side i_pbf_far_side (.clk_sys_i(clk_sys_i), .pad_out_i(pad_out_o), .pad_oe_i(pad_oe_o),
    .ext_val_i(ext_val), .ext_oe_i(ext_oe), .pad_lvl_o(pad_in_i), .per_o(pv), .per_prev_o(pq));

  always #25 clk_sys_i = ~clk_sys_i;

  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    addr_i <= a;
    wr_data_i <= d;
    wr_stb_i <= 1'b1;
    @(posedge clk_sys_i);
    wr_stb_i <= 1'b0;
    @(posedge clk_sys_i);
  endtask
  task automatic rd(input logic [3:0] a, output logic [15:0] d);
    addr_i <= a;
    rd_stb_i <= 1'b1;
    @(posedge clk_sys_i);
    rd_stb_i <= 1'b0;
    @(negedge clk_sys_i);
    d = rd_data_o;
    @(posedge clk_sys_i);
  endtask
  task automatic settle(input int n);
    repeat (n) @(posedge clk_sys_i);
    @(negedge clk_sys_i);
  endtask
  task automatic do_reset();
    rst_i <= 1'b1;
    repeat (16) @(posedge clk_sys_i);
    rst_i <= 1'b0;
    @(posedge clk_sys_i);
  endtask
  task automatic stop_test();
    $display("comparisons %0d n_fail %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  task automatic t_regs();
    logic [15:0] d;
    rd(OFS_HIGH_SEL, d);
    `CHK(d, 16'h0000)
    wr(OFS_LOW_SEL, 16'hffff);
    wr(OFS_HIGH_SEL, 16'h5a3c);
    wr(4'h6, 16'h1234);
    rd(OFS_LOW_SEL, d);
    `CHK(d, 16'hffff)
    rd(OFS_HIGH_SEL, d);
    `CHK(d, 16'h5a3c)
    rd(4'h6, d);
    `CHK(d, 16'h0000)
    do_reset();
    rd(OFS_LOW_SEL, d);
    `CHK(d, 16'h0000)
  endtask
  task automatic t_gpio();
    logic [15:0] d;
    gpio_out_i <= 16'ha5c3;
    gpio_oe_i <= 16'h0ff0;
    ext_val <= 16'h3c96;
    ext_oe <= 16'hf00f;
    settle(6);
    `CHK({pad_out_o, pad_oe_o}, {16'ha5c3, 16'h0ff0})
    `CHK(gpio_in_o, (16'ha5c3 & 16'h0ff0) | (16'h3c96 & 16'hf00f))
    @(posedge clk_sys_i);
    rd(OFS_PIN_STAT, d);
    `CHK(d, (16'ha5c3 & 16'h0ff0) | (16'h3c96 & 16'hf00f))
    ext_oe <= 16'hffff;
  endtask
  task automatic t_set_a();
    ext_val <= 16'hc369;
    wr(OFS_HIGH_SEL, 16'h0be5);
    wr(OFS_LOW_SEL, 16'h6697);
    repeat (3) begin
      settle(2);
      `CHK(pad_out_o, {gpio_out_i[15:14], pq[2], pq[4], pq[5], pq[6], 1'b0, pq[10], pq[14], pq[17], 1'b0, pq[19], pq[20], pq[22], pq[26], pq[31]})
      `CHK(pad_oe_o, {gpio_oe_i[15:14], 3'b111, pq[7], 1'b0, pq[11], 1'b1, pq[18], 2'b01, pq[21], pq[23], 2'b11})
      `CHK({timer1_capcomp_a_in_o, sync2_transmit_sync_in_o, async2_serial_clock_in_o, timer0_capcomp_a_in_o, sync1_transmit_sync_in_o}, {gpio_in_o[10], gpio_in_o[8], gpio_in_o[6], gpio_in_o[3], gpio_in_o[2]})
    end
    `CHK({sync2_transmit_clock_o, sync1_receive_sync_o, sync2_receive_clock_o}, 3'b110)
    `CHK({async1_receive_data_o, async2_receive_data_o}, {RX_IDLE, RX_IDLE})
  endtask
  task automatic t_set_b();
    @(posedge clk_sys_i);
    ext_val <= 16'h3c96;
    wr(OFS_HIGH_SEL, 16'ha59a);
    wr(OFS_LOW_SEL, 16'h996a);
    repeat (3) begin
      settle(2);
      `CHK(pad_out_o, {pq[0], 1'b0, gpio_out_i[13], 3'h0, pq[8], pq[12], pq[15], 4'h0, pq[24], pq[27], pq[29]})
      `CHK(pad_oe_o, {pq[1], 1'b0, gpio_oe_i[13], 3'h0, pq[9], pq[13], pq[16], 4'h0, pq[25], pq[28], pq[30]})
      `CHK({async1_serial_clock_in_o, timer1_capcomp_b_in_o, timer2_capcomp_a_in_o, timer2_capcomp_b_in_o, timer0_capcomp_b_in_o, timer0_capcomp_c_in_o, timer0_capcomp_d_in_o}, {gpio_in_o[15], gpio_in_o[9:7], gpio_in_o[2:0]})
    end
    `CHK({async1_receive_data_o, sync2_receive_clock_o, async1_clear_to_send_o, sync2_receive_data_o, sync1_receive_clock_o, async2_receive_data_o, sync1_receive_data_o, sync1_transmit_clock_o}, 8'b01110010)
  endtask
  task automatic t_ext_clk();
    ext_val <= 16'h0282;
    for (int k = 0; k < 4; k++) begin
      @(posedge clk_sys_i);
      timer_phase_count_i <= (k == 0);
      timer_prescale_select_i <= (k == 1) ? PSC_EXT_A : (k == 2) ? PSC_EXT_C : (k == 3) ? PSC_EXT_D : 3'h0;
      settle(6);
      `CHK({timer_ext_clock_a_o, timer_ext_clock_c_o, timer_ext_clock_d_o}, {k < 2, k == 0 || k == 2, k == 0 || k == 3})
      `CHK({pad_oe_o[1] && k < 2, pad_oe_o[9] && (k == 0 || k == 2), pad_oe_o[7] && (k == 0 || k == 3)}, 3'b000)
    end
  endtask

  initial begin
    repeat (16) @(posedge clk_sys_i);
    rst_i <= 1'b0;
    @(posedge clk_sys_i);
    t_regs();
    t_gpio();
    t_set_a();
    t_set_b();
    t_ext_clk();
    stop_test();
  end
  initial begin
    repeat (5000) @(posedge clk_sys_i);
    n_fail++;
    stop_test();
  end
endmodule

bind pbf_pin_function pbf_pin_function_properties i_pbf_pin_function_properties (.*);

`default_nettype wire
